//--- pkg/pmsv_defs.svh
// register offsets, field positions, reset values and voltage steps
// assumes: included by bare name wherever the power regs are decoded
`ifndef PMSV_DEFS_SVH
`define PMSV_DEFS_SVH

`define PMSV_ADDR_STATUS 3'h1
`define PMSV_ADDR_BUCK 3'h2
`define PMSV_ADDR_LIN1 3'h3
`define PMSV_ADDR_LIN2 3'h4

`define PMSV_BIT_BUCK_OK 0
`define PMSV_BIT_LIN1_OK 1
`define PMSV_BIT_LIN2_OK 2
`define PMSV_BIT_RSVD_LO 3
`define PMSV_BIT_TSD 4
`define PMSV_BIT_UV 5
`define PMSV_BIT_INT_EN 6
`define PMSV_BIT_RSVD_HI 7

`define PMSV_STATUS_RST 8'h00
`define PMSV_BUCK_RST 8'h00
`define PMSV_LIN1_RST 8'h00
`define PMSV_LIN2_RST 8'h00

`define PMSV_BUCK_FINE_LAST 8'h0F
`define PMSV_BUCK_COARSE_FIRST 8'h10
`define PMSV_BUCK_COARSE_LAST 8'h1C
`define PMSV_BASE_MV 12'h320
`define PMSV_BUCK_FINE_MV 12'h019
`define PMSV_BUCK_COARSE_MV 12'h4B0
`define PMSV_STEP_MV 12'h032

`endif

//--- pkg/pmsv_pkg.sv
// shared types of the power status and voltage register bank
// assumes: compiled before the interface and the design modules
`default_nettype none

package pmsv_pkg;
	typedef logic [7:0] pmsv_byte_t;
	typedef logic [11:0] pmsv_mv_t;
	typedef struct packed {
		logic rsvd_hi;
		logic int_en;
		logic input_undervolt_flag;
		logic thermal_trip_flag;
		logic rsvd_lo;
		logic linreg_two_valid;
		logic linreg_one_valid;
		logic buck_valid;
	} pmsv_status_s;
	typedef struct packed {
		logic hit;
		logic [5:0] idx;
	} pmsv_lookup_s;
endpackage

`default_nettype wire

//--- pkg/pmsv_xfer_if.sv
// toggle handshake carrying one register access between the two clocks
// assumes: link side holds its fields stable while a toggle is pending
`default_nettype none

interface pmsv_xfer_if;
	import pmsv_pkg::*;
	logic req_tgl;
	logic we;
	pmsv_byte_t addr;
	pmsv_byte_t wdata;
	logic ack_tgl;
	pmsv_byte_t rdata;
	modport link (output req_tgl, output we, output addr, output wdata,
		input ack_tgl, input rdata);
	modport core (input req_tgl, input we, input addr, input wdata,
		output ack_tgl, output rdata);
endinterface

`default_nettype wire

//--- verilog/pmsv_link_port.sv
// link-clock side of the register access: takes requests, waits for the ack
// assumes: link_clk runs from a request until link_done of that request
`default_nettype none

module pmsv_link_port
	import pmsv_pkg::*;
(
	// clock and reset
	input wire logic link_clk,
	input wire logic reset,
	// access request from the serial engine
	input wire logic link_req,
	input wire logic link_we,
	input wire pmsv_byte_t link_addr,
	input wire pmsv_byte_t link_wdata,
	output logic link_busy,
	output logic link_done,
	output pmsv_byte_t link_rdata,
	// crossing toward the core
	pmsv_xfer_if.link xfer
);
	logic ack_meta;
	logic ack_sync;
	logic ack_seen;
	logic accept;

	assign link_busy = xfer.req_tgl != ack_sync;
	assign accept = link_req && !link_busy;

	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			ack_meta <= 1'b0;
			ack_sync <= 1'b0;
		end else begin
			ack_meta <= xfer.ack_tgl;
			ack_sync <= ack_meta;
		end
	end

	// fields stay frozen until the core has acknowledged
	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			xfer.req_tgl <= 1'b0;
			xfer.we <= 1'b0;
			xfer.addr <= 8'h00;
			xfer.wdata <= 8'h00;
		end else if (accept) begin
			xfer.req_tgl <= ~xfer.req_tgl;
			xfer.we <= link_we;
			xfer.addr <= link_addr;
			xfer.wdata <= link_wdata;
		end
	end

	always_ff @(posedge link_clk or posedge reset) begin
		if (reset) begin
			ack_seen <= 1'b0;
			link_done <= 1'b0;
			link_rdata <= 8'h00;
		end else begin
			ack_seen <= ack_sync;
			link_done <= ack_sync != ack_seen;
			if (ack_sync != ack_seen) begin
				link_rdata <= xfer.rdata;
			end
		end
	end
endmodule

`default_nettype wire

//--- verilog/pmsv_regs.sv
// status, fault flag and voltage code registers of a triple supply device
// assumes: a serial engine on link_clk issues one register access at a time
`default_nettype none
`include "pmsv_defs.svh"

module pmsv_regs
	import pmsv_pkg::*;
#(
	parameter pmsv_byte_t BUCK_RESET_CODE = `PMSV_BUCK_RST,
	parameter pmsv_byte_t LIN1_RESET_CODE = `PMSV_LIN1_RST,
	parameter pmsv_byte_t LIN2_RESET_CODE = `PMSV_LIN2_RST
) (
	// system clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// link side access port
	input wire logic link_clk,
	input wire logic link_req,
	input wire logic link_we,
	input wire pmsv_byte_t link_addr,
	input wire pmsv_byte_t link_wdata,
	output logic link_busy,
	output logic link_done,
	output pmsv_byte_t link_rdata,
	// supply and fault monitors, asynchronous
	input wire logic buck_valid_raw,
	input wire logic linreg_one_valid_raw,
	input wire logic linreg_two_valid_raw,
	input wire logic main_supply_in_uv_raw,
	input wire logic thermal_trip_raw,
	// open-drain interrupt pin
	input wire logic fault_irq_n_i,
	output logic fault_irq_n_o,
	output logic fault_irq_n_oe,
	// voltage targets toward the regulators
	output pmsv_byte_t buck_code,
	output pmsv_byte_t linreg_one_code,
	output pmsv_byte_t linreg_two_code,
	output pmsv_mv_t buck_target_mv,
	output pmsv_mv_t linreg_one_target_mv,
	output pmsv_mv_t linreg_two_target_mv,
	output logic buck_code_ok,
	output logic linreg_one_code_ok,
	output logic linreg_two_code_ok
);
	if (BUCK_RESET_CODE > `PMSV_BUCK_COARSE_LAST) begin : g_chk_buck
		$error("buck reset code outside the listed range");
	end

	pmsv_xfer_if xfer ();

	logic [4:0] mon_meta;
	logic [4:0] mon_sync;
	logic req_meta;
	logic req_sync;
	logic req_seen;
	logic req_edge;
	logic [2:0] reg_sel;
	logic wr_status;
	logic clr_uv;
	logic clr_tsd;
	logic uv_cond;
	logic tsd_cond;
	logic input_undervolt_flag;
	logic thermal_trip_flag;
	logic int_en;
	pmsv_status_s status_value;
	pmsv_lookup_s lin1_look;
	pmsv_lookup_s lin2_look;

	function automatic logic buck_listed(input pmsv_byte_t code);
		return code <= `PMSV_BUCK_COARSE_LAST;
	endfunction

	function automatic pmsv_mv_t buck_mv(input pmsv_byte_t code);
		if (code <= `PMSV_BUCK_FINE_LAST) begin
			return `PMSV_BASE_MV + `PMSV_BUCK_FINE_MV * {4'h0, code};
		end
		return `PMSV_BUCK_COARSE_MV
			+ `PMSV_STEP_MV * {4'h0, code - `PMSV_BUCK_COARSE_FIRST};
	endfunction

	function automatic pmsv_mv_t step_mv(input logic [5:0] idx);
		return `PMSV_BASE_MV + `PMSV_STEP_MV * {6'h00, idx};
	endfunction

	// non-uniform code to 50 mV step index
	function automatic pmsv_lookup_s lin_lookup(input pmsv_byte_t code);
		pmsv_lookup_s r;
		r.hit = 1'b1;
		case (code)
			8'h00: r.idx = 6'h00;
			8'h0B: r.idx = 6'h01;
			8'h14: r.idx = 6'h02;
			8'h1D: r.idx = 6'h03;
			8'h25: r.idx = 6'h04;
			8'h2E: r.idx = 6'h05;
			8'h37: r.idx = 6'h06;
			8'h3E: r.idx = 6'h07;
			8'h45: r.idx = 6'h08;
			8'h4C: r.idx = 6'h09;
			8'h52: r.idx = 6'h0A;
			8'h57: r.idx = 6'h0B;
			8'h5C: r.idx = 6'h0C;
			8'h61: r.idx = 6'h0D;
			8'h65: r.idx = 6'h0E;
			8'h69: r.idx = 6'h0F;
			8'h6D: r.idx = 6'h10;
			8'h72: r.idx = 6'h11;
			8'h79: r.idx = 6'h12;
			8'h7F: r.idx = 6'h13;
			8'h85: r.idx = 6'h14;
			8'h8B: r.idx = 6'h15;
			8'h91: r.idx = 6'h16;
			8'h96: r.idx = 6'h17;
			8'h9A: r.idx = 6'h18;
			8'h9F: r.idx = 6'h19;
			8'hA4: r.idx = 6'h1A;
			8'hA8: r.idx = 6'h1B;
			8'hAC: r.idx = 6'h1C;
			8'hB0: r.idx = 6'h1D;
			8'hB4: r.idx = 6'h1E;
			8'hB7: r.idx = 6'h1F;
			8'hBA: r.idx = 6'h20;
			8'hBD: r.idx = 6'h21;
			8'hC1: r.idx = 6'h22;
			8'hC4: r.idx = 6'h23;
			8'hC7: r.idx = 6'h24;
			8'hC9: r.idx = 6'h25;
			8'hCC: r.idx = 6'h26;
			8'hCE: r.idx = 6'h27;
			8'hD1: r.idx = 6'h28;
			8'hD3: r.idx = 6'h29;
			8'hD6: r.idx = 6'h2A;
			8'hD8: r.idx = 6'h2B;
			8'hDA: r.idx = 6'h2C;
			8'hDC: r.idx = 6'h2D;
			8'hDE: r.idx = 6'h2E;
			8'hE1: r.idx = 6'h2F;
			8'hE3: r.idx = 6'h30;
			8'hE6: r.idx = 6'h31;
			8'hE8: r.idx = 6'h32;
			default: begin
				r.hit = 1'b0;
				r.idx = 6'h00;
			end
		endcase
		return r;
	endfunction

	pmsv_link_port u_link (
		.link_clk(link_clk),
		.reset(reset),
		.link_req(link_req),
		.link_we(link_we),
		.link_addr(link_addr),
		.link_wdata(link_wdata),
		.link_busy(link_busy),
		.link_done(link_done),
		.link_rdata(link_rdata),
		.xfer(xfer.link)
	);

	// monitor pins and request toggle into clk_sys
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			mon_meta <= 5'h00;
			mon_sync <= 5'h00;
			req_meta <= 1'b0;
			req_sync <= 1'b0;
			req_seen <= 1'b0;
		end else begin
			mon_meta <= {thermal_trip_raw, main_supply_in_uv_raw, linreg_two_valid_raw,
				linreg_one_valid_raw, buck_valid_raw};
			mon_sync <= mon_meta;
			req_meta <= xfer.req_tgl;
			req_sync <= req_meta;
			req_seen <= req_sync;
		end
	end

	assign req_edge = req_sync ^ req_seen;
	assign uv_cond = mon_sync[3];
	assign tsd_cond = mon_sync[4];

	assign reg_sel = xfer.addr[2:0];
	assign wr_status = req_edge && xfer.we && reg_sel == `PMSV_ADDR_STATUS;
	assign clr_uv = wr_status && xfer.wdata[`PMSV_BIT_UV];
	assign clr_tsd = wr_status && xfer.wdata[`PMSV_BIT_TSD];

	always_comb begin
		status_value = pmsv_status_s'(`PMSV_STATUS_RST);
		status_value.int_en = int_en;
		status_value.input_undervolt_flag = input_undervolt_flag;
		status_value.thermal_trip_flag = thermal_trip_flag;
		status_value.linreg_two_valid = mon_sync[2];
		status_value.linreg_one_valid = mon_sync[1];
		status_value.buck_valid = mon_sync[0];
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			input_undervolt_flag <= 1'b0;
			thermal_trip_flag <= 1'b0;
		end else begin
			input_undervolt_flag <= (input_undervolt_flag && !clr_uv) || uv_cond;
			thermal_trip_flag <= (thermal_trip_flag && !clr_tsd) || tsd_cond;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			int_en <= 1'b0;
		end else if (wr_status) begin
			int_en <= xfer.wdata[`PMSV_BIT_INT_EN];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			buck_code <= BUCK_RESET_CODE;
			linreg_one_code <= LIN1_RESET_CODE;
			linreg_two_code <= LIN2_RESET_CODE;
		end else if (req_edge && xfer.we) begin
			case (reg_sel)
				`PMSV_ADDR_BUCK: buck_code <= xfer.wdata;
				`PMSV_ADDR_LIN1: linreg_one_code <= xfer.wdata;
				`PMSV_ADDR_LIN2: linreg_two_code <= xfer.wdata;
				default: buck_code <= buck_code;
			endcase
		end
	end

	// read answer and ack, values as before the access
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			xfer.ack_tgl <= 1'b0;
			xfer.rdata <= 8'h00;
		end else if (req_edge) begin
			xfer.ack_tgl <= ~xfer.ack_tgl;
			case (reg_sel)
				`PMSV_ADDR_STATUS: xfer.rdata <= status_value;
				`PMSV_ADDR_BUCK: xfer.rdata <= buck_code;
				`PMSV_ADDR_LIN1: xfer.rdata <= linreg_one_code;
				`PMSV_ADDR_LIN2: xfer.rdata <= linreg_two_code;
				default: xfer.rdata <= 8'h00;
			endcase
		end
	end

	assign lin1_look = lin_lookup(linreg_one_code);
	assign lin2_look = lin_lookup(linreg_two_code);

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			buck_target_mv <= `PMSV_BASE_MV;
			linreg_one_target_mv <= `PMSV_BASE_MV;
			linreg_two_target_mv <= `PMSV_BASE_MV;
			buck_code_ok <= 1'b0;
			linreg_one_code_ok <= 1'b0;
			linreg_two_code_ok <= 1'b0;
		end else begin
			buck_code_ok <= buck_listed(buck_code);
			linreg_one_code_ok <= lin1_look.hit;
			linreg_two_code_ok <= lin2_look.hit;
			if (buck_listed(buck_code)) begin
				buck_target_mv <= buck_mv(buck_code);
			end
			if (lin1_look.hit) begin
				linreg_one_target_mv <= step_mv(lin1_look.idx);
			end
			if (lin2_look.hit) begin
				linreg_two_target_mv <= step_mv(lin2_look.idx);
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			fault_irq_n_oe <= 1'b0;
		end else begin
			fault_irq_n_oe <= int_en && (uv_cond || tsd_cond);
		end
	end

	assign fault_irq_n_o = 1'b0;

	a_valid_bits: assert property (@(posedge clk_sys) disable iff (reset)
		status_value[2:0] == $past({linreg_two_valid_raw, linreg_one_valid_raw, buck_valid_raw}, 2))
		else $error("valid bits do not follow monitors");
	a_uv_sets: assert property (@(posedge clk_sys) disable iff (reset)
		uv_cond |=> input_undervolt_flag)
		else $error("undervoltage flag not set");
	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (reset)
		thermal_trip_flag && !clr_tsd |=> thermal_trip_flag [*1])
		else $error("thermal flag dropped without clear");
	a_flag_clear: assert property (@(posedge clk_sys) disable iff (reset)
		clr_uv && !uv_cond |=> !input_undervolt_flag)
		else $error("undervoltage flag not cleared");
	a_fault_reset: assert property (@(posedge clk_sys) disable iff (reset)
		clr_tsd && tsd_cond |=> thermal_trip_flag)
		else $error("persisting thermal fault not re-flagged");
	a_inten_write: assert property (@(posedge clk_sys) disable iff (reset)
		wr_status |=> int_en == $past(xfer.wdata[`PMSV_BIT_INT_EN]))
		else $error("interrupt enable not written");
	a_reserved_zero: assert property (@(posedge clk_sys) disable iff (reset)
		!status_value.rsvd_hi && !status_value.rsvd_lo) else $error("reserved bit set");
	a_irq_gated: assert property (@(posedge clk_sys) disable iff (reset)
		!int_en |=> !fault_irq_n_oe) else $error("interrupt not gated by enable");
	a_buck_fine: assert property (@(posedge clk_sys) disable iff (reset)
		buck_code <= `PMSV_BUCK_FINE_LAST
		|=> buck_target_mv == `PMSV_BASE_MV + `PMSV_BUCK_FINE_MV * {4'h0, $past(buck_code)})
		else $error("fine buck voltage wrong");
	a_buck_coarse: assert property (@(posedge clk_sys) disable iff (reset)
		buck_code == `PMSV_BUCK_COARSE_LAST ##1 buck_code == `PMSV_BUCK_COARSE_LAST
		|-> buck_target_mv == 12'h708)
		else $error("coarse buck top voltage wrong");
	a_buck_write: assert property (@(posedge clk_sys) disable iff (reset)
		req_edge && xfer.we && xfer.addr[2:0] == `PMSV_ADDR_BUCK
		|=> buck_code == $past(xfer.wdata))
		else $error("buck code not written at its address");
	a_lin_top: assert property (@(posedge clk_sys) disable iff (reset)
		linreg_two_code == 8'hE8 |=> linreg_two_target_mv == 12'hCE4 && linreg_two_code_ok)
		else $error("linear top code not 3300 mV");
	a_irq_follow: assert property (@(posedge clk_sys) disable iff (reset)
		int_en && (uv_cond || tsd_cond) |=> fault_irq_n_oe && !fault_irq_n_o)
		else $error("interrupt pin not driven on fault");
	a_addr_alias: assert property (@(posedge clk_sys) disable iff (reset)
		req_edge && xfer.we && xfer.addr[7:3] != 5'h00 && xfer.addr[2:0] == `PMSV_ADDR_LIN1
		|=> linreg_one_code == $past(xfer.wdata))
		else $error("upper address bits not ignored");
	a_zero_hold: assert property (@(posedge clk_sys) disable iff (reset)
		wr_status && !xfer.wdata[`PMSV_BIT_UV] && input_undervolt_flag
		|=> input_undervolt_flag)
		else $error("zero write cleared a flag");
endmodule

`default_nettype wire

//--- dv/pmsv_host_model.sv
// link-side host model: one register access at a time on its own clock
// assumes: pmsv_regs link port; link clock runs only in reset and accesses
`default_nettype none

module pmsv_host_model
	import pmsv_pkg::*;
(
	// link clock, made here
	output logic link_clk,
	input wire logic reset,
	// access port
	output logic link_req,
	output logic link_we,
	output pmsv_byte_t link_addr,
	output pmsv_byte_t link_wdata,
	input wire logic link_busy,
	input wire logic link_done,
	input wire pmsv_byte_t link_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic act;
	initial begin
		link_clk = 1'b0;
		act = 1'b0;
		link_req = 1'b0;
		link_we = 1'b0;
		link_addr = 8'h00;
		link_wdata = 8'h00;
		#7;
		forever begin
			#32;
			if (reset || act || link_clk) begin
				link_clk = ~link_clk;
			end
		end
	end
	// request held one cycle, then address and data released to inverted values, we kept
	task automatic access(input logic we, input pmsv_byte_t addr, input pmsv_byte_t wdata,
		output pmsv_byte_t rdata, output logic ok);
		logic seen;
		logic fin;
		ok = 1'b0;
		fin = 1'b0;
		rdata = 8'h00;
		act = 1'b1;
		@(negedge link_clk);
		link_req = 1'b1;
		link_we = we;
		link_addr = addr;
		link_wdata = wdata;
		@(negedge link_clk);
		link_req = 1'b0;
		seen = link_busy === 1'b1;
		link_addr = ~addr;
		link_wdata = ~wdata;
		// ok needs busy while pending and busy low once done
		for (int n = 0; n < 10 && !fin; n++) begin
			@(negedge link_clk);
			if (link_done === 1'b1) begin
				fin = 1'b1;
				ok = seen && link_busy === 1'b0;
				rdata = link_rdata;
			end
		end
		act = 1'b0;
	endtask
endmodule

`default_nettype wire

//--- dv/testbench.sv
// self-checking bench of the power status and voltage registers
// assumes: host model drives the link port; monitors driven at clk_sys fall
`default_nettype none

`define CHK(got, exp) begin \
	n_compared++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
	end \
end

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import pmsv_pkg::*;
	logic clk_sys, reset, link_clk, link_req, link_we, link_busy, link_done;
	pmsv_byte_t link_addr, link_wdata, link_rdata, buck_code, linreg_one_code, linreg_two_code;
	pmsv_mv_t buck_target_mv, linreg_one_target_mv, linreg_two_target_mv;
	logic buck_valid_raw, linreg_one_valid_raw, linreg_two_valid_raw;
	logic main_supply_in_uv_raw, thermal_trip_raw, fault_irq_n_o, fault_irq_n_oe;
	logic buck_code_ok, linreg_one_code_ok, linreg_two_code_ok;
	wire fault_irq_n = fault_irq_n_oe ? fault_irq_n_o : 1'b1;
	int n_mismatch = 0;
	int n_compared = 0;
	int cycles = 0;

	pmsv_regs u_dut (.clk_sys(clk_sys), .reset(reset), .link_clk(link_clk),
		.link_req(link_req), .link_we(link_we), .link_addr(link_addr),
		.link_wdata(link_wdata), .link_busy(link_busy), .link_done(link_done),
		.link_rdata(link_rdata), .buck_valid_raw(buck_valid_raw),
		.linreg_one_valid_raw(linreg_one_valid_raw), .linreg_two_valid_raw(linreg_two_valid_raw),
		.main_supply_in_uv_raw(main_supply_in_uv_raw), .thermal_trip_raw(thermal_trip_raw),
		.fault_irq_n_i(fault_irq_n), .fault_irq_n_o(fault_irq_n_o),
		.fault_irq_n_oe(fault_irq_n_oe), .buck_code(buck_code),
		.linreg_one_code(linreg_one_code), .linreg_two_code(linreg_two_code),
		.buck_target_mv(buck_target_mv), .linreg_one_target_mv(linreg_one_target_mv),
		.linreg_two_target_mv(linreg_two_target_mv), .buck_code_ok(buck_code_ok),
		.linreg_one_code_ok(linreg_one_code_ok), .linreg_two_code_ok(linreg_two_code_ok));

	pmsv_host_model u_host (.link_clk(link_clk), .reset(reset), .link_req(link_req),
		.link_we(link_we), .link_addr(link_addr), .link_wdata(link_wdata),
		.link_busy(link_busy), .link_done(link_done), .link_rdata(link_rdata));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles > 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic acc(input logic we, input pmsv_byte_t a, input pmsv_byte_t d,
		output pmsv_byte_t r);
		logic ok;
		u_host.access(we, a, d, r, ok);
		`CHK(ok, 1'b1)
		repeat (3) @(negedge clk_sys);
	endtask

	task automatic wr(input pmsv_byte_t a, input pmsv_byte_t d);
		pmsv_byte_t r;
		acc(1'b1, a, d, r);
	endtask

	task automatic rchk(input pmsv_byte_t a, input pmsv_byte_t e);
		pmsv_byte_t r;
		acc(1'b0, a, 8'h00, r);
		`CHK(r, e)
	endtask

	// monitor levels {thermal, undervolt, lin2, lin1, buck}
	task automatic mon(input logic [4:0] v);
		@(negedge clk_sys);
		{thermal_trip_raw, main_supply_in_uv_raw, linreg_two_valid_raw} = v[4:2];
		{linreg_one_valid_raw, buck_valid_raw} = v[1:0];
		repeat (6) @(negedge clk_sys);
	endtask

	task automatic t_reset();
		rchk(8'h01, 8'h00);
		`CHK(fault_irq_n_oe, 1'b0)
		`CHK(buck_target_mv, 12'h320)
	endtask

	task automatic t_valid();
		for (int i = 0; i < 3; i++) begin
			mon(5'(1 << i));
			rchk(8'h01, 8'(1 << i));
		end
		mon(5'h07);
		wr(8'h01, 8'h8F);
		rchk(8'h01, 8'h07);
		rchk(8'h09, 8'h07);
		wr(8'h05, 8'hFF);
		rchk(8'h05, 8'h00);
		rchk(8'h01, 8'h07);
	endtask

	task automatic t_flags();
		mon(5'h0F);
		mon(5'h07);
		rchk(8'h01, 8'h27);
		wr(8'h01, 8'h00);
		rchk(8'h01, 8'h27);
		mon(5'h17);
		rchk(8'h01, 8'h37);
		wr(8'h01, 8'h20);
		rchk(8'h01, 8'h17);
		wr(8'h01, 8'h10);
		rchk(8'h01, 8'h17);
		mon(5'h07);
		wr(8'h01, 8'h10);
		rchk(8'h01, 8'h07);
	endtask

	task automatic t_irq();
		mon(5'h0F);
		`CHK(fault_irq_n_oe, 1'b0)
		wr(8'h01, 8'h40);
		rchk(8'h01, 8'h67);
		`CHK(fault_irq_n_oe, 1'b1)
		`CHK(fault_irq_n, 1'b0)
		mon(5'h17);
		`CHK(fault_irq_n_oe, 1'b1)
		mon(5'h07);
		`CHK(fault_irq_n_oe, 1'b0)
		wr(8'h01, 8'h30);
		rchk(8'h01, 8'h07);
	endtask

	task automatic t_buck();
		pmsv_byte_t c[5] = '{8'h00, 8'h0F, 8'h10, 8'h1C, 8'h1D};
		pmsv_byte_t r;
		pmsv_byte_t prev;
		pmsv_mv_t e;
		logic ok;
		prev = 8'h00;
		e = 12'h320;
		for (int i = 0; i < 5; i++) begin
			ok = (c[i] <= 8'h1C);
			if (c[i] < 8'h10) e = 12'h320 + 12'(c[i]) * 12'h019;
			else if (ok) e = 12'h4B0 + 12'(c[i] - 8'h10) * 12'h032;
			acc(1'b1, 8'hFA, c[i], r);
			`CHK(r, prev)
			`CHK(buck_code, c[i])
			`CHK(buck_target_mv, e)
			`CHK(buck_code_ok, ok)
			rchk(8'h02, c[i]);
			prev = c[i];
		end
	endtask

	task automatic t_lin();
		// last entry unlisted, target must hold
		pmsv_byte_t c[5] = '{8'h0B, 8'hBA, 8'hE8, 8'h00, 8'h01};
		pmsv_mv_t m[5] = '{12'h352, 12'h960, 12'hCE4, 12'h320, 12'h320};
		for (int j = 0; j < 2; j++) begin
			for (int i = 0; i < 5; i++) begin
				wr(8'hF3 + 8'(j), c[i]);
				`CHK(j ? linreg_two_code : linreg_one_code, c[i])
				`CHK(j ? linreg_two_target_mv : linreg_one_target_mv, m[i])
				`CHK(j ? linreg_two_code_ok : linreg_one_code_ok, i < 4)
				rchk(8'h03 + 8'(j), c[i]);
			end
		end
	endtask

	// mid-run reset must drop enable and sticky flag
	task automatic t_rst_mid();
		mon(5'h0F);
		wr(8'h01, 8'h40);
		mon(5'h00);
		`CHK(fault_irq_n_oe, 1'b0)
		reset = 1'b1;
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		repeat (4) @(negedge clk_sys);
		rchk(8'h01, 8'h00);
		`CHK(fault_irq_n_oe, 1'b0)
	endtask

	initial begin
		reset = 1'b1;
		{buck_valid_raw, linreg_one_valid_raw, linreg_two_valid_raw} = 3'h0;
		{main_supply_in_uv_raw, thermal_trip_raw} = 2'h0;
		repeat (4) @(negedge clk_sys);
		reset = 1'b0;
		repeat (4) @(negedge clk_sys);
		t_reset();
		t_valid();
		t_flags();
		t_irq();
		t_buck();
		t_lin();
		t_rst_mid();
		report_and_stop();
	end
endmodule

`default_nettype wire
